/* File: src/ctx_ram_consts.vh */
// Constants for the context memory read/write command interpreter
`ifndef CTX_RAM_CONSTS_VH
`define CTX_RAM_CONSTS_VH
`define OP_READ_RAM 3'h2
`define OP_WRITE_RAM 3'h3
`define OPC_HI 15
`define OPC_LO 13
`define DIS_DEST_BIT 12
`define CNT_HI_HI 13
`define CNT_HI_LO 12
`define WCNT_HI_HI 15
`define WCNT_HI_LO 14
`define ADDR_HI_W 11
`define ADDR_LO_W 14
`define ADDR_W 25
`define CNT_W 18
`define OVERRUN_BIT 9
`define MEM_DEPTH 256
`define MEM_AW 8
`endif

/* File: src/ctx_ram_cmd.v */
// Context memory read/write command interpreter with result assembly
`timescale 1ns/1ns
`include "ctx_ram_consts.vh"

// Summary of operation
// - Opcode 2 in top bits of word 0 reads, opcode 3 writes memory.
// - Read fetches a contiguous memory block and sends it as destination output.
// - Read takes four words from command stream, two from source stream.
// - Write stores the source block into context memory.
// - Read length counts bytes, start address counts 16-bit words.
// - Write length counts bytes, start address counts 16-bit words.
// - Start address is a word index into memory.
// - Destination output is 32-bit aligned and padded to whole words.
// - Base result reports count of meaningful destination bytes.
// - Results come base first, then compression, MAC, encryption.
// - Results of units not enabled are omitted.
// - Base result is always written.
// - Write source input is an unstructured byte stream; read source carries address low bits and count.
module ctx_ram_cmd (
  input wire core_clk,
  input wire resetn,
  input wire clk_en,
  input wire [15:0] cmd_data,
  input wire cmd_valid,
  output reg cmd_ready,
  input wire [15:0] src_data,
  input wire src_valid,
  output reg src_ready,
  output reg [31:0] dest_data,
  output reg dest_valid,
  input wire dest_ready,
  output reg [15:0] res_data,
  output reg res_valid,
  input wire res_ready,
  output reg busy,
  output reg bad_opcode
);

// --------------------------------------------------------------
// State and storage
// --------------------------------------------------------------
// Sequencer states
localparam S_IDLE = 3'h0;
localparam S_CMD = 3'h1;
localparam S_SRCH = 3'h2;
localparam S_RUN = 3'h3;
localparam S_DRAIN = 3'h4;
localparam S_RES = 3'h5;

reg [2:0] st_q;
reg [1:0] wix_q;
reg [2:0] op_q;
reg dis_q;
reg [`ADDR_W-1:0] addr_q;
reg [`CNT_W-1:0] cnt_q;
reg [`CNT_W-1:0] left_q;
reg [`CNT_W-1:0] sent_q;
reg hi_q;
reg [15:0] mem_q [0:`MEM_DEPTH-1];
reg [1:0] rix_q;
reg [15:0] half_q;
reg half_v_q;
// Only the low word address bits index the modelled memory; higher bits alias
wire [`MEM_AW-1:0] mix = addr_q[`MEM_AW-1:0];
// Two-entry destination buffer
reg [31:0] fb_q [0:1];
reg [1:0] fcnt_q;
reg fwp_q;
reg frp_q;
wire f_full = (fcnt_q == 2'h2);
wire f_push_ok = !f_full;
reg f_push;
reg [31:0] f_word;
wire f_pop = dest_valid && dest_ready;
// Only a read that keeps its output has meaningful destination bytes
wire read_kept = !dis_q && (op_q == `OP_READ_RAM);
wire [`CNT_W-1:0] dest_bytes = read_kept ? cnt_q : {`CNT_W{1'b0}};
// Overrun compares the padded bytes sent with the requested count
wire overrun = read_kept && (sent_q > cnt_q);

// --------------------------------------------------------------
// Command handling
// --------------------------------------------------------------
// Sequencer: command words, source words, memory moves, then results
always @(posedge core_clk) begin
  if (!resetn) begin
    st_q <= S_IDLE;
    wix_q <= 2'h0;
    op_q <= 3'h0;
    dis_q <= 1'b0;
    addr_q <= {`ADDR_W{1'b0}};
    cnt_q <= {`CNT_W{1'b0}};
    left_q <= {`CNT_W{1'b0}};
    sent_q <= {`CNT_W{1'b0}};
    hi_q <= 1'b0;
    rix_q <= 2'h0;
    half_q <= 16'h0000;
    half_v_q <= 1'b0;
    bad_opcode <= 1'b0;
    busy <= 1'b0;
    cmd_ready <= 1'b0;
    src_ready <= 1'b0;
    f_push <= 1'b0;
    f_word <= 32'h00000000;
  end else if (clk_en) begin
    // A low clock enable skips this branch and so holds every register
    f_push <= 1'b0;
    case (st_q)
      S_IDLE: begin
        cmd_ready <= 1'b1;
        busy <= 1'b0;
        wix_q <= 2'h0;
        sent_q <= {`CNT_W{1'b0}};
        half_v_q <= 1'b0;
        rix_q <= 2'h0;
        // Clear the count so a refused command reports no stale bytes
        cnt_q <= {`CNT_W{1'b0}};
        if (cmd_valid && cmd_ready) begin
          op_q <= cmd_data[`OPC_HI:`OPC_LO];
          dis_q <= cmd_data[`DIS_DEST_BIT] && (cmd_data[`OPC_HI:`OPC_LO] == `OP_READ_RAM);
          bad_opcode <= (cmd_data[`OPC_HI:`OPC_LO] != `OP_READ_RAM) &&
                        (cmd_data[`OPC_HI:`OPC_LO] != `OP_WRITE_RAM);
          busy <= 1'b1;
          wix_q <= 2'h1;
          st_q <= S_CMD;
        end
      end
      S_CMD: begin
        if (cmd_valid && cmd_ready) begin
          wix_q <= wix_q + 2'h1;
          // Fields of word 1 and, for a write, words 2 and 3; rest is zero fill
          if (wix_q == 2'h1) begin
            addr_q[`ADDR_W-1:`ADDR_LO_W] <= cmd_data[`ADDR_HI_W-1:0];
            if (op_q == `OP_READ_RAM)
              cnt_q[`CNT_W-1:16] <= cmd_data[`CNT_HI_HI:`CNT_HI_LO];
            else
              cnt_q[`CNT_W-1:16] <= cmd_data[`WCNT_HI_HI:`WCNT_HI_LO];
          end
          if (wix_q == 2'h2 && op_q == `OP_WRITE_RAM)
            cnt_q[15:0] <= cmd_data;
          if (wix_q == 2'h3 && op_q == `OP_WRITE_RAM)
            addr_q[`ADDR_LO_W-1:0] <= cmd_data[`ADDR_LO_W-1:0];
          if (wix_q == 2'h3) begin
            // Host pads command to 8 bytes; remaining words ignored
            cmd_ready <= 1'b0;
            if (bad_opcode) begin
              st_q <= S_RES;
            end else if (op_q == `OP_READ_RAM) begin
              src_ready <= 1'b1;
              rix_q <= 2'h0;
              st_q <= S_SRCH;
            end else begin
              // A write goes straight to storing source words
              src_ready <= 1'b1;
              st_q <= S_RUN;
            end
          end
        end
      end
      S_SRCH: begin
        // Second half of the read structure comes from the source stream
        if (src_valid && src_ready) begin
          rix_q <= rix_q + 2'h1;
          if (rix_q == 2'h0)
            addr_q[`ADDR_LO_W-1:0] <= src_data[`ADDR_LO_W-1:0];
          else begin
            cnt_q[15:0] <= src_data;
            left_q <= {cnt_q[`CNT_W-1:16], src_data};
            src_ready <= 1'b0;
            hi_q <= 1'b0;
            st_q <= S_RUN;
          end
        end
      end
      S_RUN: begin
        if (op_q == `OP_WRITE_RAM) begin
          // Source is a plain byte stream taken two bytes per word
          if (cnt_q == {`CNT_W{1'b0}}) begin
            src_ready <= 1'b0;
            st_q <= S_RES;
          end else if (src_valid && src_ready) begin
            mem_q[mix] <= src_data;
            addr_q <= addr_q + 25'h0000001;
            if (cnt_q <= 18'h00002) begin
              cnt_q <= {`CNT_W{1'b0}};
              src_ready <= 1'b0;
              st_q <= S_RES;
            end else
              cnt_q <= cnt_q - 18'h00002;
          end
        end else if (left_q == {`CNT_W{1'b0}}) begin
          st_q <= S_DRAIN;
        end else if (f_push_ok && !f_push) begin
          // A push still in flight is not yet counted, so wait it out to avoid overfill
          // Pack memory halfwords into 32-bit destination words
          addr_q <= addr_q + 25'h0000001;
          if (left_q <= 18'h00002)
            left_q <= {`CNT_W{1'b0}};
          else
            left_q <= left_q - 18'h00002;
          if (!hi_q) begin
            half_q <= mem_q[mix];
            half_v_q <= 1'b1;
            hi_q <= 1'b1;
          end else begin
            f_word <= {half_q, mem_q[mix]};
            f_push <= !dis_q;
            sent_q <= sent_q + 18'h00004;
            half_v_q <= 1'b0;
            hi_q <= 1'b0;
          end
        end
      end
      S_DRAIN: begin
        // Odd halfword is padded out to a full word
        if (half_v_q && f_push_ok && !f_push) begin
          f_word <= {half_q, 16'h0000};
          f_push <= !dis_q;
          sent_q <= sent_q + 18'h00004;
          half_v_q <= 1'b0;
        end else if (!half_v_q && !f_push && fcnt_q == 2'h0) begin
          // Results start only once the host has taken every destination word
          rix_q <= 2'h0;
          st_q <= S_RES;
        end
      end
      S_RES: begin
        // Only the base result: no processing unit is enabled here
        if (res_valid && res_ready) begin
          rix_q <= rix_q + 2'h1;
          if (rix_q == 2'h3)
            st_q <= S_IDLE;
        end
      end
      default: st_q <= S_IDLE;
    endcase
  end
end

// --------------------------------------------------------------
// Base result words
// --------------------------------------------------------------
// Four base result words, each held until the host takes it
always @(posedge core_clk) begin
  if (!resetn) begin
    res_valid <= 1'b0;
    res_data <= 16'h0000;
  end else if (clk_en) begin
    if (st_q == S_RES && !(res_valid && res_ready && rix_q == 2'h3)) begin
      res_valid <= 1'b1;
      // Word order: overrun flag, count high bits, zero word, count low bits
      case (rix_q + (res_valid && res_ready ? 2'h1 : 2'h0))
        2'h0: res_data <= {6'h00, overrun, 9'h000};
        2'h1: res_data <= {2'h0, dest_bytes[17:16], 12'h000};
        2'h2: res_data <= 16'h0000;
        default: res_data <= dest_bytes[15:0];
      endcase
    end else begin
      res_valid <= 1'b0;
    end
  end
end

// --------------------------------------------------------------
// Destination buffer
// --------------------------------------------------------------
// Head entry is copied to the output register so dest_data leaves a flop
always @(posedge core_clk) begin
  if (!resetn) begin
    fcnt_q <= 2'h0;
    fwp_q <= 1'b0;
    frp_q <= 1'b0;
    dest_valid <= 1'b0;
    dest_data <= 32'h00000000;
    fb_q[0] <= 32'h00000000;
    fb_q[1] <= 32'h00000000;
  end else if (clk_en) begin
    if (f_push) begin
      fb_q[fwp_q] <= f_word;
      fwp_q <= ~fwp_q;
    end
    if (f_pop)
      frp_q <= ~frp_q;
    // Count moves by push minus pop; both may fall in one cycle
    fcnt_q <= fcnt_q + {1'b0, f_push} - {1'b0, f_pop};
    // Output register shows the head entry
    if (!dest_valid || f_pop) begin
      if ((fcnt_q - {1'b0, f_pop}) != 2'h0) begin
        dest_valid <= 1'b1;
        dest_data <= fb_q[f_pop ? ~frp_q : frp_q];
      end else if (f_push) begin
        dest_valid <= 1'b1;
        dest_data <= f_word;
      end else
        dest_valid <= 1'b0;
    end
  end
end

endmodule // ctx_ram_cmd

/* File: testbench/host_sink.sv */
// Host-side sink model that takes destination and result words
`timescale 1ns/1ns
module host_sink (
  input wire core_clk,
  input wire resetn,
  input wire slow,
  output reg dest_ready,
  output reg res_ready
);
  reg [1:0] tick_q;
  // Host takes every word, or stalls three cycles in four when slow
  always @(posedge core_clk) begin
    tick_q <= resetn ? tick_q + 2'h1 : 2'h0;
    dest_ready <= resetn && (!slow || tick_q == 2'h0);
    res_ready <= resetn && (!slow || tick_q == 2'h2);
  end
endmodule // host_sink

/* File: testbench/ctx_ram_cmd_chk.sv */
// Assertions on the ports of the context memory command interpreter
`timescale 1ns/1ns
module ctx_ram_cmd_chk (
  input wire core_clk,
  input wire resetn,
  input wire clk_en,
  input wire [15:0] cmd_data,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [31:0] dest_data,
  input wire dest_valid,
  input wire dest_ready,
  input wire [15:0] res_data,
  input wire res_valid,
  input wire res_ready,
  input wire busy,
  input wire bad_opcode
);
  reg [1:0] idx_q;
  reg [1:0] rcnt_q;
  reg [2:0] op_q;
  reg dis_q;
  // Track opcode, discard bit and result words of the command in hand
  always @(posedge core_clk) begin
    if (!resetn) begin
      idx_q <= 2'h0;
      rcnt_q <= 2'h0;
      op_q <= 3'h0;
      dis_q <= 1'h0;
    end else if (clk_en) begin
      if (res_valid && res_ready) rcnt_q <= rcnt_q + 2'h1;
      if (cmd_valid && cmd_ready) idx_q <= idx_q + 2'h1;
      if (cmd_valid && cmd_ready && idx_q == 2'h0) op_q <= cmd_data[15:13];
      if (cmd_valid && cmd_ready && idx_q == 2'h0) dis_q <= cmd_data[12];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_reset_quiet: assert property (disable iff (1'h0)
    !resetn && clk_en |=> !dest_valid && !res_valid && !busy) else $error("active in reset");
  a_dest_hold: assert property (
    dest_valid && !dest_ready |=> dest_valid && $stable(dest_data)) else $error("dest dropped");
  a_res_hold: assert property (
    res_valid && !res_ready |=> res_valid && $stable(res_data)) else $error("result dropped");
  a_dest_read_only: assert property (
    dest_valid |-> op_q == 3'h2) else $error("dest outside read");
  a_discard_dest: assert property (
    op_q == 3'h2 && dis_q |-> !dest_valid) else $error("discarded dest shown");
  a_res_after_dest: assert property (
    res_valid |-> !dest_valid) else $error("result before dest done");
  a_bad_flag: assert property (
    $rose(bad_opcode) |-> op_q != 3'h2 && op_q != 3'h3) else $error("flag on good opcode");
  a_whole_base: assert property (
    cmd_valid && cmd_ready && idx_q == 2'h0 |-> rcnt_q == 2'h0) else $error("base cut short");
  a_enable_freeze: assert property (
    !clk_en |=> $stable(dest_data) && $stable(dest_valid) && $stable(res_data) &&
      $stable(res_valid) && $stable(cmd_ready) && $stable(busy)) else $error("moved while frozen");
endmodule // ctx_ram_cmd_chk
bind ctx_ram_cmd ctx_ram_cmd_chk ctx_ram_cmd_chk_inst (.core_clk(core_clk), .resetn(resetn),
  .clk_en(clk_en), .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .dest_data(dest_data), .dest_valid(dest_valid), .dest_ready(dest_ready),
  .res_data(res_data), .res_valid(res_valid), .res_ready(res_ready), .busy(busy),
  .bad_opcode(bad_opcode));

/* File: testbench/context_ram_cmd_and_result_format_test.sv */
// Self-checking bench for the context memory command interpreter
`timescale 1ns/1ns
module context_ram_cmd_and_result_format_test;
  reg core_clk = 1'h0, resetn = 1'h0, clk_en = 1'h1, slow = 1'h0, cmd_valid = 1'h0;
  reg src_valid = 1'h0;
  reg [15:0] cmd_data = 16'h0000, src_data = 16'h0000;
  wire cmd_ready, src_ready, dest_valid, dest_ready, res_valid, res_ready, busy, bad_opcode;
  wire [31:0] dest_data;
  wire [15:0] res_data;
  int bad_count = 0, cmp_count = 0;
  logic [31:0] dq [$];
  logic [15:0] rq [$];
  // Rows: opcode, discard, word address, bytes, two dest words, result words 0 and 3
  logic [31:0] tb [0:5][0:7] = '{
    '{32'h3, 32'h0, 32'h80, 32'h8, 32'h0, 32'h0, 32'h0, 32'h0},
    '{32'h2, 32'h0, 32'h80, 32'h8, 32'hA101A202, 32'hA303A404, 32'h0, 32'h8},
    '{32'h2, 32'h0, 32'h81, 32'h6, 32'hA202A303, 32'hA4040000, 32'h200, 32'h6},
    '{32'h2, 32'h1, 32'h80, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0},
    '{32'h2, 32'h0, 32'h4080, 32'h4, 32'hA101A202, 32'h0, 32'h0, 32'h4},
    '{32'h5, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0}};
  ctx_ram_cmd ctx_ram_cmd_inst (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .src_data(src_data),
    .src_valid(src_valid), .src_ready(src_ready), .dest_data(dest_data),
    .dest_valid(dest_valid), .dest_ready(dest_ready), .res_data(res_data),
    .res_valid(res_valid), .res_ready(res_ready), .busy(busy), .bad_opcode(bad_opcode));
  host_sink host_sink_inst (.core_clk(core_clk), .resetn(resetn), .slow(slow),
    .dest_ready(dest_ready), .res_ready(res_ready));
  // Clock at 25 MHz
  initial forever #20 core_clk = ~core_clk;
  // Collect words the host accepts
  always @(posedge core_clk) begin
    if (clk_en && dest_valid && dest_ready) dq.push_back(dest_data);
    if (clk_en && res_valid && res_ready) rq.push_back(res_data);
  end
  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // Offer one word on the command (s=0) or source (s=1) stream until taken
  task put(input logic s, input logic [15:0] w);
    cmd_data <= s ? cmd_data : w;
    src_data <= s ? w : src_data;
    cmd_valid <= !s;
    src_valid <= s;
    @(posedge core_clk);
    while (!clk_en || (s ? src_ready : cmd_ready) !== 1'h1) @(posedge core_clk);
  endtask
  // Run one table row and check dest and result streams
  task run(input int i);
    logic [31:0] a, n;
    int e;
    a = tb[i][2];
    n = tb[i][3];
    e = (tb[i][0] == 2 && tb[i][1] == 0) ? (n + 3) / 4 : 0;
    dq.delete();
    rq.delete();
    slow <= i[0];
    put(0, {tb[i][0][2:0], tb[i][1][0], 12'h000});
    if (tb[i][0] == 3) begin
      put(0, {n[17:16], 3'h0, a[24:14]});
      put(0, n[15:0]);
      put(0, {2'h0, a[13:0]});
      for (int k = 0; k < (n + 1) / 2; k++) put(1, 16'hA000 + 16'h0101 * (k + 1));
    end else begin
      put(0, {2'h0, n[17:16], 1'h0, a[24:14]});
      put(0, 16'h0000);
      put(0, 16'h0000);
      if (tb[i][0] == 2) put(1, {2'h0, a[13:0]});
      if (tb[i][0] == 2) put(1, n[15:0]);
    end
    cmd_valid <= 1'h0;
    src_valid <= 1'h0;
    for (int k = 0; k < 500 && rq.size() < 4; k++) @(posedge core_clk);
    check(rq.size(), 32'h4);
    check(dq.size(), e);
    for (int k = 0; k < e; k++) check(dq[k], tb[i][4 + k]);
    check(rq[0], tb[i][6]);
    check({rq[1], rq[2]}, 32'h0);
    check(rq[3], tb[i][7]);
    check(bad_opcode, tb[i][0] != 2 && tb[i][0] != 3);
    $display("row %0d done", i);
  endtask
  // Print the counts and the verdict, then stop
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #800000;
    bad_count++;
    close_out();
  end
  // Table rows, then a reset between rows and recovery
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'h1;
    for (int i = 0; i < 6; i++) run(i);
    resetn <= 1'h0;
    repeat (4) @(posedge core_clk);
    check({busy, dest_valid, res_valid}, 32'h0);
    $display("reset test done");
    resetn <= 1'h1;
    run(0);
    // Clock enable toggled every cycle while a read row runs
    fork
      run(2);
      repeat (60) begin
        @(posedge core_clk);
        clk_en <= ~clk_en;
      end
    join
    $display("freeze test done");
    close_out();
  end
endmodule // context_ram_cmd_and_result_format_test
